/* File: verilog/serial_crc24_generator.sv */
// Bit-serial 24-bit check generator: passes data bits through and appends check field.
// Assumes an upstream framer on the same clock driving start, valid, data and last.
//
// Operation
// - Check uses polynomial x^24 + x^23 + x^6 + x^5 + x + 1.
// - All 24 register stages are zero before each stream's first bit.
// - Register advances once per data bit, b0 first through bN-1.
// - After the last bit, stages c0..c23 hold the check result.
// - Output sends data bits first, then c23 down to c0 last.
// - For M below 24, send only c23 down to c(24-M), that last.
`timescale 1ns/1ps
module serial_crc24_generator
    import crc24_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic       in_valid,
    input  wire logic       in_bit,
    input  wire logic       in_last,
    input  wire logic [4:0] chk_len,
    output logic            in_ready,
    output logic            out_valid,
    output logic            out_bit,
    output logic            out_last,
    input  wire logic       out_ready,
    output logic            busy
);
    // ********************************
    // Types and state
    // ********************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_CHK  = 2'b11
    } gen_state_e;

    gen_state_e  state_r;
    logic [23:0] crc_r;
    logic [4:0]  chk_cnt_r;
    logic [4:0]  chk_len_r;
    logic        tx_valid_r;
    logic        tx_bit_r;
    logic        tx_last_r;
    logic        in_ready_r;
    logic        busy_r;
    logic        take;
    logic        out_take;
    logic        fifo_push;
    logic        fifo_pop;
    logic        chk_final;
    logic        has_room;
    logic [4:0]  fill_r;
    logic [4:0]  fill_nxt;
    logic [4:0]  tail_r;

    bit_fifo_if #(.W(FIFO_WIDTH)) fq ();

    bit_fifo #(
        .W     (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk  (clk),
        .srst (srst),
        .f    (fq.fifo)
    );

    // ********************************
    // Check register step
    // ********************************
    function automatic logic [23:0] crc_step(input logic [23:0] c, input logic b);
        logic fb;
        fb = c[23] ^ b;
        crc_step = {c[22:0], 1'b0} ^ ({24{fb}} & CRC_POLY);
    endfunction

    function automatic logic [4:0] clamp_len(input logic [4:0] m);
        if (m > CHK_LEN_FULL || m < CHK_LEN_MIN) begin
            clamp_len = CHK_LEN_FULL;
        end else begin
            clamp_len = m;
        end
    endfunction

    // ********************************
    // Control decode
    // ********************************
    // Data is accepted only while in a stream and the buffer has room
    assign take      = in_valid && in_ready_r && (state_r == ST_DATA);
    assign out_take  = tx_valid_r && out_ready;
    assign fifo_push = fq.in_valid && fq.in_ready;
    assign fifo_pop  = fq.out_valid && fq.out_ready;
    assign has_room  = (fill_nxt != 5'(FIFO_DEPTH));
    assign chk_final = (state_r == ST_CHK) && fq.in_ready
                       && (chk_cnt_r == chk_len_r - 5'h01);

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r   <= ST_IDLE;
            chk_len_r <= CHK_LEN_FULL;
            chk_cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r   <= ST_DATA;
                        chk_len_r <= clamp_len(chk_len);
                    end
                end
                ST_DATA: begin
                    if (take && in_last) begin
                        state_r   <= ST_CHK;
                        chk_cnt_r <= '0;
                    end
                end
                ST_CHK: begin
                    // Check bits go into the buffer only behind all data bits
                    if (fq.in_ready) begin
                        chk_cnt_r <= chk_cnt_r + 5'h01;
                        if (chk_cnt_r == chk_len_r - 5'h01) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            crc_r <= CRC_INIT;
        end else if (state_r == ST_IDLE && start) begin
            crc_r <= CRC_INIT;
        end else if (take) begin
            crc_r <= crc_step(crc_r, in_bit);
        end
    end

    // ********************************
    // Buffer feed: data then check bits
    // ********************************
    // Check bits are read as crc_r[23 - k]: c23 first, c(24-M) last
    always_comb begin
        fq.in_valid = 1'b0;
        fq.in_data  = 1'b0;
        if (take) begin
            fq.in_valid = 1'b1;
            fq.in_data  = in_bit;
        end else if (state_r == ST_CHK) begin
            fq.in_valid = 1'b1;
            fq.in_data  = crc_r[5'h17 - chk_cnt_r];
        end
    end

    // Ready is registered, so it is judged on the fill of the next cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            in_ready_r <= 1'b0;
            busy_r     <= 1'b0;
        end else begin
            in_ready_r <= has_room && !(take && in_last)
                          && (state_r == ST_DATA || (state_r == ST_IDLE && start));
            busy_r     <= (state_r != ST_IDLE) || fq.out_valid || tx_valid_r;
        end
    end

    // ********************************
    // Buffer occupancy and frame end
    // ********************************
    // Mirror of the buffer fill, so the registered ready never admits a bit
    // into a buffer that is full by the time the bit arrives
    always_comb begin
        fill_nxt = fill_r;
        if (fifo_push && !fifo_pop) begin
            fill_nxt = fill_r + 5'h01;
        end else if (fifo_pop && !fifo_push) begin
            fill_nxt = fill_r - 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fill_r <= '0;
        end else begin
            fill_r <= fill_nxt;
        end
    end

    // Place of the final check bit counted from the buffer head.
    // A new frame whose final check bit enters before this drains would lose the end mark.
    always_ff @(posedge clk) begin
        if (srst) begin
            tail_r <= '0;
        end else if (chk_final) begin
            tail_r <= fill_nxt;
        end else if (fifo_pop && tail_r != 5'h00) begin
            tail_r <= tail_r - 5'h01;
        end
    end

    // ********************************
    // Output stage
    // ********************************
    assign fq.out_ready = !tx_valid_r || out_take;

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_valid_r <= 1'b0;
            tx_bit_r   <= 1'b0;
            tx_last_r  <= 1'b0;
        end else if (fq.out_ready) begin
            tx_valid_r <= fq.out_valid;
            tx_bit_r   <= fq.out_data;
            tx_last_r  <= fq.out_valid && (tail_r == 5'h01);
        end
    end

    // ********************************
    // Output ports
    // ********************************
    assign in_ready  = in_ready_r;
    assign out_valid = tx_valid_r;
    assign out_bit   = tx_bit_r;
    assign out_last  = tx_last_r;
    assign busy      = busy_r;
endmodule

/* File: verilog/crc24_pkg.sv */
// Constants shared by the serial check generator and its bit buffer.
// Assumes a single 20 MHz clock domain and synchronous reset.
package crc24_pkg;
    localparam int          CRC_W        = 24;
    localparam logic [23:0] CRC_POLY     = 24'h800063;
    localparam logic [23:0] CRC_INIT     = 24'h000000;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          FIFO_WIDTH   = 1;
    localparam logic [4:0]  CHK_LEN_FULL = 5'h18;
    localparam logic [4:0]  CHK_LEN_MIN  = 5'h01;
endpackage

/* File: verilog/bit_fifo_if.sv */
// Carrier between the check generator and its bit buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface bit_fifo_if #(parameter int W = 1) ();
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: verilog/bit_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; srst empties it.
`timescale 1ns/1ps
module bit_fifo #(
    parameter int W     = 1,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic srst,
    bit_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   count_r;
    logic          push;
    logic          pop;

    assign f.in_ready  = (count_r != (AW+1)'(DEPTH));
    assign f.out_valid = (count_r != '0);
    assign f.out_data  = mem[rd_ptr_r];
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= f.in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            case ({push, pop})
                2'b10:   count_r <= count_r + (AW+1)'(1);
                2'b01:   count_r <= count_r - (AW+1)'(1);
                default: count_r <= count_r;
            endcase
        end
    end
endmodule

/* File: verif/crc24_framer_model.sv */
// Upstream framer model: start pulse, then one data bit per valid beat.
// Assumes the generator samples its inputs on the rising clock edge.
`timescale 1ns/1ps
module crc24_framer_model (
    input  wire logic clk,
    output logic      start,
    output logic      in_valid,
    output logic      in_bit,
    output logic      in_last,
    input  wire logic in_ready
);
    initial begin
        start = 1'b0;
        in_valid = 1'b0;
        in_bit = 1'b0;
        in_last = 1'b0;
    end
    // Slow mode drops valid between bits; the released data line shows
    // the inverse so a stale bit can never be taken by accident.
    task automatic send(input logic [63:0] d, input int n, input logic slow);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            in_valid <= 1'b1;
            in_bit <= d[i];
            in_last <= (i == n - 1);
            do @(posedge clk); while (in_ready !== 1'b1);
            if (slow || i == n - 1) begin
                in_valid <= 1'b0;
                in_last <= 1'b0;
                in_bit <= ~d[i];
                if (slow) @(posedge clk);
            end
        end
    endtask
endmodule

/* File: verif/serial_crc24_generator_properties.sv */
// Port-level checks of the serial check generator.
// Assumes bind onto the generator top; srst is synchronous active high.
`timescale 1ns/1ps
module serial_crc24_generator_properties (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       start,
    input wire logic       in_valid,
    input wire logic       in_bit,
    input wire logic       in_last,
    input wire logic [4:0] chk_len,
    input wire logic       in_ready,
    input wire logic       out_valid,
    input wire logic       out_bit,
    input wire logic       out_last,
    input wire logic       out_ready,
    input wire logic       busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [4:0] m_r;
    logic [7:0] n_r;
    logic [7:0] o_r;
    // Frame bookkeeping: bits in, bits out, appended length
    always_ff @(posedge clk) begin
        if (srst) begin
            m_r <= 5'h00;
            n_r <= 8'h00;
            o_r <= 8'h00;
        end else if (start && !busy) begin
            m_r <= (chk_len == 5'h00 || chk_len > 5'h18) ? 5'h18 : chk_len;
            n_r <= 8'h00;
            o_r <= 8'h00;
        end else begin
            n_r <= n_r + 8'(in_valid && in_ready);
            o_r <= o_r + 8'(out_valid && out_ready);
        end
    end
    sequence s_first_take;
        start && !busy ##1 in_valid && in_ready && out_ready ##1 out_ready;
    endsequence
    property p_reset_quiet; $fell(srst) |-> !out_valid && !in_ready && !busy; endproperty
    property p_out_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_bit) && $stable(out_last);
    endproperty
    property p_first_out; s_first_take |=> out_valid && out_bit == $past(in_bit, 2); endproperty
    property p_ready_start; start && !busy |=> in_ready; endproperty
    property p_busy_start; start && !busy |-> ##[1:2] busy; endproperty
    property p_last_refuse; in_valid && in_ready && in_last |=> !in_ready; endproperty
    property p_last_idle; out_valid && out_ready && out_last |-> ##[1:3] !busy; endproperty
    property p_frame_len;
        out_valid && out_ready && out_last |-> o_r + 8'h01 == n_r + {3'h0, m_r};
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    a_out_hold: assert property (p_out_hold) else $error("output changed while stalled");
    a_first_out: assert property (p_first_out) else $error("first bit late or wrong");
    a_ready_start: assert property (p_ready_start) else $error("no ready after start");
    a_busy_start: assert property (p_busy_start) else $error("busy not raised");
    a_last_refuse: assert property (p_last_refuse) else $error("bit taken after last");
    a_last_idle: assert property (p_last_idle) else $error("busy stuck after frame");
    a_frame_len: assert property (p_frame_len) else $error("wrong output length");
endmodule

/* File: verif/serial_crc24_generator_bench.sv */
// Random frames with corner lengths through the generator, output stalls.
// Assumes the framer model drives the data side of the generator.
`timescale 1ns/1ps
module serial_crc24_generator_bench;
    import crc24_pkg::*;
    logic       clk = 1'b0, srst = 1'b1, out_ready = 1'b0;
    logic [4:0] chk_len = 5'h00;
    logic       start, in_valid, in_bit, in_last, in_ready, out_valid, out_bit, out_last, busy;
    int         err_total = 0, checks = 0, cyc = 0, last_at = 0, seed = 32'hA64D;
    logic       got_q[$];
    logic [4:0] lens[8] = '{5'h18, 5'h01, 5'h00, 5'h1F, 5'h17, 5'h0C, 5'h19, 5'h02};
    always #25 clk = ~clk;
    serial_crc24_generator u_serial_crc24_generator (.clk, .srst, .start, .in_valid,
        .in_bit, .in_last, .chk_len, .in_ready, .out_valid, .out_bit, .out_last,
        .out_ready, .busy);
    crc24_framer_model u_crc24_framer_model (.clk, .start, .in_valid, .in_bit, .in_last,
        .in_ready);
    // Long periodic stalls fill the 16-bit buffer until it refuses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        out_ready <= (cyc[6:5] == 2'b00) ? 1'b0 : 1'($random(seed));
        if (out_valid && out_ready) got_q.push_back(out_bit);
        if (out_valid && out_ready && out_last) last_at = got_q.size();
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end
    function automatic logic [23:0] crc_of(logic [63:0] d, int n);
        logic [23:0] c;
        c = 24'h000000;
        for (int i = 0; i < n; i++) c = {c[22:0], 1'b0} ^ ((d[i] ^ c[23]) ? 24'h800063 : 24'h0);
        return c;
    endfunction
    task automatic cmp_bit(input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t bit got %b expected %b", $time, g, e);
        end
    endtask
    task automatic cmp_num(input int e, input int g);
        checks++;
        if (g != e) begin
            err_total++;
            $display("[FAIL] %0t count got %0d expected %0d", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            int          n, m;
            logic [63:0] d;
            logic [23:0] c;
            n = (k == 0) ? 1 : (k == 1) ? 64 : 1 + int'($unsigned($random(seed)) % 64);
            d = {$random(seed), $random(seed)};
            m = (lens[k % 8] == 5'h00 || lens[k % 8] > 5'h18) ? 24 : int'(lens[k % 8]);
            c = crc_of(d, n);
            got_q.delete();
            last_at = 0;
            chk_len <= lens[k % 8];
            u_crc24_framer_model.send(d, n, k[0]);
            for (int w = 0; w < 3000 && last_at == 0; w++) @(posedge clk);
            cmp_num(n + m, got_q.size());
            cmp_num(n + m, last_at);
            for (int i = 0; i < n + m && i < got_q.size(); i++)
                cmp_bit(i < n ? d[i] : c[23 - (i - n)], got_q[i]);
            for (int w = 0; w < 20 && busy !== 1'b0; w++) @(posedge clk);
            $display("frame %0d done: %0d data bits, %0d check bits", k, n, m);
        end
        report_and_stop();
    end
endmodule
bind serial_crc24_generator serial_crc24_generator_properties u_props (.clk, .srst, .start,
    .in_valid, .in_bit, .in_last, .chk_len, .in_ready, .out_valid, .out_bit, .out_last,
    .out_ready, .busy);
